// file: src/mcs_pkg.sv
// Constants shared by the microcontroller core sequencer, its assertions and its bench
package mcs_pkg;
   // I/O addresses and fields handled inside the core
   localparam logic [7:0] IO_PSC_ADDR = 8'hFF;
   localparam logic [7:0] IO_USBSC_ADDR = 8'h1F;
   localparam int EP_SIZE_BIT = 7;
   // Reset values
   localparam logic [7:0] PSC_RESET = 8'h00;
   localparam logic [13:0] PC_RESET = 14'h0000;
   localparam logic [7:0] PSP_RESET = 8'h00;
   localparam logic [7:0] DSP_RESET = 8'h00;
   localparam logic [3:0] CNT_RESET = 4'h0;
   // Single opcodes
   localparam logic [7:0] OP_HALT = 8'h00;
   localparam logic [7:0] OP_ALU_FIRST = 8'h01;
   localparam logic [7:0] OP_ALU_LAST = 8'h1B;
   localparam logic [7:0] OP_MOVX_I = 8'h1C;
   localparam logic [7:0] OP_MOVX_D = 8'h1D;
   localparam logic [7:0] OP_PAGE_ADV = 8'h1F;
   localparam logic [7:0] OP_INC_A = 8'h21;
   localparam logic [7:0] OP_INC_X = 8'h22;
   localparam logic [7:0] OP_INC_D = 8'h23;
   localparam logic [7:0] OP_INC_I = 8'h24;
   localparam logic [7:0] OP_DEC_A = 8'h25;
   localparam logic [7:0] OP_DEC_X = 8'h26;
   localparam logic [7:0] OP_DEC_D = 8'h27;
   localparam logic [7:0] OP_DEC_I = 8'h28;
   localparam logic [7:0] OP_PORT_READ = 8'h29;
   localparam logic [7:0] OP_PORT_WRITE = 8'h2A;
   localparam logic [7:0] OP_POP_A = 8'h2B;
   localparam logic [7:0] OP_POP_X = 8'h2C;
   localparam logic [7:0] OP_PUSH_A = 8'h2D;
   localparam logic [7:0] OP_PUSH_X = 8'h2E;
   localparam logic [7:0] OP_SWAP_AX = 8'h2F;
   localparam logic [7:0] OP_SWAP_ADSP = 8'h30;
   localparam logic [7:0] OP_STA_D = 8'h31;
   localparam logic [7:0] OP_STA_I = 8'h32;
   localparam logic [7:0] OP_ORM_D = 8'h33;
   localparam logic [7:0] OP_ORM_I = 8'h34;
   localparam logic [7:0] OP_ANDM_D = 8'h35;
   localparam logic [7:0] OP_ANDM_I = 8'h36;
   localparam logic [7:0] OP_XORM_D = 8'h37;
   localparam logic [7:0] OP_XORM_I = 8'h38;
   localparam logic [7:0] OP_IDX_PORT_WRITE = 8'h39;
   localparam logic [7:0] OP_CPL = 8'h3A;
   localparam logic [7:0] OP_ASL = 8'h3B;
   localparam logic [7:0] OP_ASR = 8'h3C;
   localparam logic [7:0] OP_RLC = 8'h3D;
   localparam logic [7:0] OP_RRC = 8'h3E;
   localparam logic [7:0] OP_SUB_RETURN = 8'h3F;
   localparam logic [7:0] OP_MOV_AX = 8'h40;
   localparam logic [7:0] OP_MOV_XA = 8'h41;
   localparam logic [7:0] OP_SET_PSP = 8'h60;
   localparam logic [7:0] OP_INT_DISABLE = 8'h70;
   localparam logic [7:0] OP_INT_ENABLE = 8'h72;
   localparam logic [7:0] OP_INT_RETURN = 8'h73;
   // Upper nibbles of control transfers
   localparam logic [3:0] NIB_CALL_HI = 4'h5;
   localparam logic [3:0] NIB_JMP = 4'h8;
   localparam logic [3:0] NIB_CALL_LO = 4'h9;
   localparam logic [3:0] NIB_BR_Z = 4'hA;
   localparam logic [3:0] NIB_BR_NZ = 4'hB;
   localparam logic [3:0] NIB_BR_C = 4'hC;
   localparam logic [3:0] NIB_BR_NC = 4'hD;
   localparam logic [3:0] NIB_ACC_JMP = 4'hE;
   localparam logic [3:0] NIB_TABLE = 4'hF;
   // Arithmetic groups and operand modes of the triplet block
   localparam logic [3:0] GRP_ADD = 4'h0;
   localparam logic [3:0] GRP_ADC = 4'h1;
   localparam logic [3:0] GRP_SUB = 4'h2;
   localparam logic [3:0] GRP_SBB = 4'h3;
   localparam logic [3:0] GRP_OR = 4'h4;
   localparam logic [3:0] GRP_AND = 4'h5;
   localparam logic [3:0] GRP_XOR = 4'h6;
   localparam logic [3:0] GRP_CMP = 4'h7;
   localparam logic [3:0] GRP_MOV = 4'h8;
   localparam logic [1:0] MODE_IMM = 2'h0;
   localparam logic [1:0] MODE_DIR = 2'h1;
   localparam logic [1:0] MODE_IDX = 2'h2;
   // Cycle counts
   localparam logic [3:0] CYC_BASE = 4'h4;
   localparam logic [3:0] CYC_FIVE = 4'h5;
   localparam logic [3:0] CYC_SIX = 4'h6;
   localparam logic [3:0] CYC_SEVEN = 4'h7;
   localparam logic [3:0] CYC_EIGHT = 4'h8;
   localparam logic [3:0] CYC_HALT = 4'h7;
   localparam logic [3:0] CYC_BR_TAKEN = 4'h5;
   localparam logic [3:0] CYC_BR_FALL = 4'h4;
   localparam logic [3:0] CYC_JMP = 4'h5;
   localparam logic [3:0] CYC_CALL = 4'hA;
   localparam logic [3:0] CYC_ACC_JMP = 4'h7;
   localparam logic [3:0] CYC_TABLE = 4'hE;
   localparam logic [3:0] CYC_RETURN = 4'h8;
   localparam logic [3:0] CYC_IRQ = 4'hA;
   // Core run state
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_HALT = 1'b1
   } mcs_state_t;
endpackage : mcs_pkg

// file: src/mcs_data_ram.sv
// 256-byte data RAM with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
module mcs_data_ram (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write port
   input wire logic we_i,
   input wire logic [7:0] waddr_i,
   input wire logic [7:0] wdata_i,
   // Read port
   input wire logic [7:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [256];

   ////////////////////////////////////////////////////////////////////////////////
   // Array has no reset, contents are undefined until written
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Read data comes a cycle after the address
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule : mcs_data_ram
`default_nettype wire

// file: src/mcs_core.sv
// Instruction sequencer, decoder and datapath of the 8-bit microcontroller core
`timescale 1ns/10ps
`default_nettype none
module mcs_core
   import mcs_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Program memory
   output logic [13:0] prom_addr_o,
   input wire logic [7:0] prom_data_i,
   // I/O port
   output logic [7:0] io_addr_o,
   output logic [7:0] io_wdata_o,
   output logic io_wr_o,
   output logic io_rd_o,
   input wire logic [7:0] io_rdata_i,
   // Interrupt request from the controller
   input wire logic irq_i,
   input wire logic [7:0] irq_vec_i,
   output logic irq_ack_o,
   // Status
   output logic [7:0] psc_o,
   output logic ep_size_o,
   output logic halted_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic [3:0] grp_f(input logic [7:0] op);
      logic [7:0] idx;
      idx = op - OP_ALU_FIRST;
      grp_f = 4'(idx / 8'h03);
   endfunction : grp_f

   function automatic logic [1:0] mode_f(input logic [7:0] op);
      logic [7:0] idx;
      idx = op - OP_ALU_FIRST;
      mode_f = 2'(idx % 8'h03);
   endfunction : mode_f

   function automatic logic br_take_f(input logic [7:0] op, input logic c, input logic z);
      br_take_f = (op[7:4] == NIB_BR_Z && z) || (op[7:4] == NIB_BR_NZ && !z) ||
                  (op[7:4] == NIB_BR_C && c) || (op[7:4] == NIB_BR_NC && !c);
   endfunction : br_take_f

   function automatic logic two_byte_f(input logic [7:0] op);
      case (op) inside
         [OP_ALU_FIRST:OP_MOVX_D], OP_INC_D, OP_INC_I, OP_DEC_D, OP_DEC_I: two_byte_f = 1'b1;
         OP_PORT_READ, OP_PORT_WRITE, [OP_STA_D:OP_IDX_PORT_WRITE]: two_byte_f = 1'b1;
         [8'h50:8'h5F], [8'h80:8'hFF]: two_byte_f = 1'b1;
         default: two_byte_f = 1'b0;
      endcase
   endfunction : two_byte_f

   // Cycle count of each opcode
   function automatic logic [3:0] cyc_f(input logic [7:0] op, input logic c, input logic z);
      logic [1:0] m;
      m = mode_f(op);
      case (op) inside
         OP_HALT: cyc_f = CYC_HALT;
         [OP_ALU_FIRST:OP_ALU_LAST]: begin
            if (grp_f(op) == GRP_CMP) begin
               cyc_f = (m == MODE_IMM) ? CYC_FIVE : (m == MODE_DIR) ? CYC_SEVEN : CYC_EIGHT;
            end else if (grp_f(op) == GRP_MOV) begin
               cyc_f = (m == MODE_IMM) ? CYC_BASE : (m == MODE_DIR) ? CYC_FIVE : CYC_SIX;
            end else begin
               cyc_f = (m == MODE_IMM) ? CYC_BASE : (m == MODE_DIR) ? CYC_SIX : CYC_SEVEN;
            end
         end
         OP_MOVX_D, OP_PORT_READ, OP_PORT_WRITE, OP_STA_D: cyc_f = CYC_FIVE;
         [OP_PUSH_A:OP_SWAP_ADSP]: cyc_f = CYC_FIVE;
         OP_INC_D, OP_DEC_D, OP_ORM_D, OP_ANDM_D, OP_XORM_D: cyc_f = CYC_SEVEN;
         OP_INC_I, OP_DEC_I, OP_ORM_I, OP_ANDM_I, OP_XORM_I: cyc_f = CYC_EIGHT;
         OP_STA_I, OP_IDX_PORT_WRITE: cyc_f = CYC_SIX;
         OP_SUB_RETURN, OP_INT_RETURN: cyc_f = CYC_RETURN;
         [8'h50:8'h5F], [8'h90:8'h9F]: cyc_f = CYC_CALL;
         [8'h80:8'h8F]: cyc_f = CYC_JMP;
         [8'hA0:8'hDF]: cyc_f = br_take_f(op, c, z) ? CYC_BR_TAKEN : CYC_BR_FALL;
         [8'hE0:8'hEF]: cyc_f = CYC_ACC_JMP;
         [8'hF0:8'hFF]: cyc_f = CYC_TABLE;
         default: cyc_f = CYC_BASE;
      endcase
   endfunction : cyc_f

   function automatic logic [13:0] pc_inc_f(input logic [13:0] pc);
      pc_inc_f = {pc[13:8], 8'(pc[7:0] + 8'h01)};
   endfunction : pc_inc_f

   ////////////////////////////////////////////////////////////////////////////////
   // State
   mcs_state_t st_q, st_d;
   logic [13:0] pc_q, pc_d, prom_addr_d;
   logic [7:0] op_q, op_d, opr_q, opr_d, a_q, a_d, x_q, x_d;
   logic [7:0] psp_q, psp_d, dsp_q, dsp_d, psc_q, psc_d, hold_q, hold_d, vec_q, vec_d;
   logic [7:0] io_addr_d, io_wdata_d;
   logic [7:0] io_addr_q_w, io_wdata_q_w;
   logic [3:0] cnt_q, cnt_d;
   logic c_q, c_d, z_q, z_d, ie_q, ie_d, irq_q, irq_d, eps_q, eps_d;
   logic io_wr_d, io_rd_d, irq_ack_d;
   logic ram_we;
   logic [7:0] ram_waddr, ram_wdata, ram_rdata, pa;
   logic [8:0] tmp9;
   logic tbl_sel;

   // Decoded fields of the current instruction
   wire [7:0] op_cur = (cnt_q == CNT_RESET) ? prom_data_i : op_q;
   wire [3:0] ncyc = irq_q ? CYC_IRQ : cyc_f(op_cur, c_q, z_q);
   wire last = (cnt_q == 4'(ncyc - 4'h1));
   wire [3:0] nib = op_q[7:4];
   wire is_alu = (op_q >= OP_ALU_FIRST) && (op_q <= OP_ALU_LAST);
   wire [3:0] grp = grp_f(op_q);
   wire [1:0] mode = mode_f(op_q);
   wire is_call = !irq_q && (nib == NIB_CALL_HI || nib == NIB_CALL_LO);
   wire is_ret = !irq_q && (op_q == OP_SUB_RETURN || op_q == OP_INT_RETURN);
   wire is_pop = !irq_q && (op_q == OP_POP_A || op_q == OP_POP_X);
   wire indexed = is_alu ? (mode == MODE_IDX) : (op_q == OP_INC_I || op_q == OP_DEC_I ||
                  op_q == OP_STA_I || op_q == OP_ORM_I || op_q == OP_ANDM_I || op_q == OP_XORM_I);
   wire [7:0] ea = indexed ? 8'(opr_q + x_q) : opr_q;
   wire imm = (is_alu && mode == MODE_IMM) || op_q == OP_MOVX_I;
   wire [7:0] val = imm ? opr_q : ram_rdata;
   wire [8:0] alu_add = {1'b0, a_q} + {1'b0, val} + {8'h00, grp == GRP_ADC && c_q};
   wire [8:0] alu_sub = {1'b0, a_q} - {1'b0, val} - {8'h00, grp == GRP_SBB && c_q};
   wire [11:0] tgt12 = {op_q[3:0], opr_q};
   wire [11:0] acc_tgt = 12'(tgt12 + {4'h0, a_q});
   wire [7:0] stack_hi = {c_q, z_q, pc_q[13:8]};
   // Return pops read one below the pointer as it walks down
   wire [7:0] ram_raddr = is_ret ? 8'(psp_q - 8'h01) : is_pop ? dsp_q : ea;

   // Data RAM holding both stacks, variables and endpoint buffers
   mcs_data_ram u_ram (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .we_i(ram_we),
      .waddr_i(ram_waddr),
      .wdata_i(ram_wdata),
      .raddr_i(ram_raddr),
      .rdata_o(ram_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer: fetch in cycles 0-1, stack/port in 2, execute in 3, return pop in 4
   always_comb begin
      st_d = st_q; pc_d = pc_q; op_d = op_q; opr_d = opr_q; a_d = a_q; x_d = x_q;
      psp_d = psp_q; dsp_d = dsp_q; c_d = c_q; z_d = z_q; ie_d = ie_q; irq_d = irq_q;
      vec_d = vec_q; hold_d = hold_q; psc_d = psc_q; eps_d = eps_q;
      io_addr_d = io_addr_q_w; io_wdata_d = io_wdata_q_w;
      io_wr_d = 1'b0; io_rd_d = 1'b0; irq_ack_d = 1'b0;
      ram_we = 1'b0; ram_waddr = ea; ram_wdata = a_q; tbl_sel = 1'b0;
      tmp9 = 9'h000;
      pa = (op_q == OP_IDX_PORT_WRITE) ? 8'(prom_data_i + x_q) : prom_data_i;
      cnt_d = 4'(cnt_q + 4'h1);
      if (st_q == ST_HALT) begin
         cnt_d = cnt_q;
      end else begin
         if (cnt_q == 4'h0) begin
            if (irq_q) begin
               ie_d = 1'b0;
            end else begin
               op_d = prom_data_i;
               pc_d = pc_inc_f(pc_q);
            end
         end
         if (cnt_q == 4'h1 && !irq_q) begin
            if (two_byte_f(op_q)) begin
               opr_d = prom_data_i;
               pc_d = pc_inc_f(pc_q);
            end
            // Internal register is served here and never strobed outward
            if (op_q == OP_PORT_READ) begin
               io_addr_d = pa;
               io_rd_d = (pa != IO_PSC_ADDR);
            end else if (op_q == OP_PORT_WRITE || op_q == OP_IDX_PORT_WRITE) begin
               io_addr_d = pa;
               io_wdata_d = a_q;
               io_wr_d = (pa != IO_PSC_ADDR);
               if (pa == IO_PSC_ADDR) psc_d = a_q;
               if (pa == IO_USBSC_ADDR) eps_d = a_q[EP_SIZE_BIT];
            end
         end
         if (cnt_q == 4'h2) begin
            if (!irq_q && op_q == OP_PORT_READ) begin
               a_d = (io_addr_q_w == IO_PSC_ADDR) ? psc_q : io_rdata_i;
            end
            if (is_call || irq_q) begin
               ram_we = 1'b1;
               ram_waddr = psp_q;
               ram_wdata = pc_q[7:0];
               psp_d = 8'(psp_q + 8'h01);
            end
            if (is_ret) psp_d = 8'(psp_q - 8'h01);
            if (!irq_q && nib == NIB_TABLE) tbl_sel = 1'b1;
         end
         if (cnt_q == 4'h3) begin
            if (is_call || irq_q) begin
               ram_we = 1'b1;
               ram_waddr = psp_q;
               ram_wdata = stack_hi;
               psp_d = 8'(psp_q + 8'h01);
            end else if (is_ret) begin
               hold_d = ram_rdata;
               psp_d = 8'(psp_q - 8'h01);
            end else if (is_alu) begin
               if (grp == GRP_MOV) begin
                  a_d = val;
               end else if (grp == GRP_CMP) begin
                  c_d = alu_sub[8];
                  z_d = (a_q == val);
               end else begin
                  tmp9 = (grp <= GRP_ADC) ? alu_add : (grp <= GRP_SBB) ? alu_sub :
                         (grp == GRP_OR) ? {c_q, a_q | val} :
                         (grp == GRP_AND) ? {c_q, a_q & val} : {c_q, a_q ^ val};
                  a_d = tmp9[7:0];
                  c_d = tmp9[8];
                  z_d = (tmp9[7:0] == 8'h00);
               end
            end else if (nib == NIB_TABLE) begin
               a_d = prom_data_i;
            end else begin
               unique case (op_q)
                  OP_MOVX_I, OP_MOVX_D: x_d = val;
                  OP_PAGE_ADV: pc_d = {6'(pc_q[13:8] + 6'h01), pc_q[7:0]};
                  OP_INC_A, OP_INC_X, OP_INC_D, OP_INC_I, OP_DEC_A, OP_DEC_X, OP_DEC_D,
                  OP_DEC_I: begin
                     tmp9 = (op_q == OP_INC_A || op_q == OP_DEC_A) ? {1'b0, a_q} :
                            (op_q == OP_INC_X || op_q == OP_DEC_X) ? {1'b0, x_q} :
                            {1'b0, ram_rdata};
                     tmp9 = (op_q <= OP_INC_I) ? 9'(tmp9 + 9'h001) : 9'(tmp9 - 9'h001);
                     c_d = tmp9[8];
                     z_d = (tmp9[7:0] == 8'h00);
                     if (op_q == OP_INC_A || op_q == OP_DEC_A) a_d = tmp9[7:0];
                     else if (op_q == OP_INC_X || op_q == OP_DEC_X) x_d = tmp9[7:0];
                     else begin
                        ram_we = 1'b1;
                        ram_wdata = tmp9[7:0];
                     end
                  end
                  OP_POP_A, OP_POP_X: begin
                     if (op_q == OP_POP_A) a_d = ram_rdata;
                     else x_d = ram_rdata;
                     dsp_d = 8'(dsp_q + 8'h01);
                  end
                  OP_PUSH_A, OP_PUSH_X: begin
                     dsp_d = 8'(dsp_q - 8'h01);
                     ram_we = 1'b1;
                     ram_waddr = 8'(dsp_q - 8'h01);
                     ram_wdata = (op_q == OP_PUSH_A) ? a_q : x_q;
                  end
                  OP_SWAP_AX: begin
                     a_d = x_q;
                     x_d = a_q;
                  end
                  OP_SWAP_ADSP: begin
                     a_d = dsp_q;
                     dsp_d = a_q;
                  end
                  OP_STA_D, OP_STA_I: ram_we = 1'b1;
                  OP_ORM_D, OP_ORM_I, OP_ANDM_D, OP_ANDM_I, OP_XORM_D, OP_XORM_I: begin
                     ram_we = 1'b1;
                     ram_wdata = (op_q <= OP_ORM_I) ? (ram_rdata | a_q) :
                                 (op_q <= OP_ANDM_I) ? (ram_rdata & a_q) : (ram_rdata ^ a_q);
                     z_d = (ram_wdata == 8'h00);
                  end
                  OP_CPL: begin
                     a_d = ~a_q;
                     z_d = (a_q == 8'hFF);
                  end
                  OP_ASL: {c_d, a_d} = {a_q, 1'b0};
                  OP_ASR: {a_d, c_d} = {a_q[7], a_q};
                  OP_RLC: {c_d, a_d} = {a_q, c_q};
                  OP_RRC: {a_d, c_d} = {c_q, a_q};
                  OP_MOV_AX: a_d = x_q;
                  OP_MOV_XA: x_d = a_q;
                  OP_SET_PSP: psp_d = a_q;
                  OP_INT_DISABLE: ie_d = 1'b0;
                  OP_INT_ENABLE: ie_d = 1'b1;
                  default: ;
               endcase
            end
         end
         if (cnt_q == 4'h4 && is_ret) begin
            pc_d = {hold_q[5:0], ram_rdata};
            if (op_q == OP_INT_RETURN) begin
               {c_d, z_d} = hold_q[7:6];
               ie_d = 1'b1;
            end
         end
         if (last) begin
            cnt_d = CNT_RESET;
            if (irq_q) begin
               irq_d = 1'b0;
               pc_d = {6'h00, vec_q};
            end else begin
               if (nib == NIB_JMP || (br_take_f(op_q, c_q, z_q))) pc_d = {pc_q[13:12], tgt12};
               if (is_call) pc_d = {1'b0, nib == NIB_CALL_HI, tgt12};
               if (nib == NIB_ACC_JMP) pc_d = {pc_q[13:12], acc_tgt};
               if (op_q == OP_HALT) st_d = ST_HALT;
            end
            if (!irq_q && op_q != OP_HALT && ie_d && irq_i) begin
               irq_d = 1'b1;
               irq_ack_d = 1'b1;
               vec_d = irq_vec_i;
            end
         end
      end
      prom_addr_d = tbl_sel ? {pc_q[13:12], acc_tgt} : pc_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   assign io_addr_o = io_addr_q_w;
   assign io_wdata_o = io_wdata_q_w;
   assign psc_o = psc_q;
   assign ep_size_o = eps_q;
   assign halted_o = st_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= ST_RUN; pc_q <= PC_RESET; prom_addr_o <= PC_RESET;
         psp_q <= PSP_RESET; dsp_q <= DSP_RESET;
         op_q <= 8'h00; opr_q <= 8'h00; a_q <= 8'h00; x_q <= 8'h00; cnt_q <= CNT_RESET;
         c_q <= 1'b0; z_q <= 1'b0; ie_q <= 1'b0; irq_q <= 1'b0; vec_q <= 8'h00;
         hold_q <= 8'h00; psc_q <= PSC_RESET; eps_q <= 1'b0; irq_ack_o <= 1'b0;
         io_addr_q_w <= 8'h00; io_wdata_q_w <= 8'h00; io_wr_o <= 1'b0; io_rd_o <= 1'b0;
      end else begin
         st_q <= st_d; pc_q <= pc_d; prom_addr_o <= prom_addr_d;
         psp_q <= psp_d; dsp_q <= dsp_d;
         op_q <= op_d; opr_q <= opr_d; a_q <= a_d; x_q <= x_d; cnt_q <= cnt_d;
         c_q <= c_d; z_q <= z_d; ie_q <= ie_d; irq_q <= irq_d; vec_q <= vec_d;
         hold_q <= hold_d; psc_q <= psc_d; eps_q <= eps_d; irq_ack_o <= irq_ack_d;
         io_addr_q_w <= io_addr_d; io_wdata_q_w <= io_wdata_d;
         io_wr_o <= io_wr_d; io_rd_o <= io_rd_d;
      end
   end
endmodule : mcs_core
`default_nettype wire

// file: tb/mcs_prom_model.sv
// Program memory model answering from the fetch address in the same cycle
`timescale 1ns/10ps
`default_nettype none
module mcs_prom_model (
   // Fetch port
   input wire logic [13:0] addr_i,
   output logic [7:0] data_o
);
   // Unloaded space reads as a no-op, so top 32 bytes never hold code
   // Filled at declaration so bench loads at time zero are never overwritten
   logic [7:0] mem [0:16383] = '{default: 8'h20};
   assign data_o = mem[addr_i];
endmodule : mcs_prom_model
`default_nettype wire

// file: tb/mcs_core_asserts.sv
// Concurrent checks on the core sequencer ports
`timescale 1ns/10ps
`default_nettype none
module mcs_core_asserts import mcs_pkg::*; (
   // Clock, reset and watched ports
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [13:0] prom_addr_o,
   input wire logic [7:0] io_addr_o,
   input wire logic [7:0] io_wdata_o,
   input wire logic io_wr_o,
   input wire logic io_rd_o,
   input wire logic [7:0] irq_vec_i,
   input wire logic irq_ack_o,
   input wire logic ep_size_o,
   input wire logic halted_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////
   // Strobes are single pulses; the vector bound covers the whole pseudo-op
   a_reset_pc: assert property ($rose(rst_n_i) |-> prom_addr_o == PC_RESET)
      else $error("first fetch not at zero");
   a_wr_pulse: assert property (io_wr_o |=> !io_wr_o) else $error("long write");
   a_rd_pulse: assert property (io_rd_o |=> !io_rd_o) else $error("long read");
   a_psc_internal: assert property (io_wr_o |-> io_addr_o != IO_PSC_ADDR)
      else $error("status write on bus");
   a_ep_size_bit: assert property (io_wr_o && io_addr_o == IO_USBSC_ADDR
      |=> ep_size_o == io_wdata_o[EP_SIZE_BIT]) else $error("size bit");
   a_ack_pulse: assert property (irq_ack_o |=> !irq_ack_o) else $error("long ack");
   a_ack_vector: assert property (irq_ack_o
      |-> ##[1:12] prom_addr_o == {6'h00, irq_vec_i}) else $error("no vector jump");
   a_halt_sticky: assert property (halted_o |=> halted_o && !irq_ack_o)
      else $error("left halt");
endmodule : mcs_core_asserts
bind mcs_core mcs_core_asserts u_mcs_core_asserts (.*);
`default_nettype wire

// file: tb/mcu_core_sequencing_test.sv
// Self-checking bench running short programs through the core sequencer
`timescale 1ns/10ps
`default_nettype none
module mcu_core_sequencing_test import mcs_pkg::*;;
   // Stimulus, observed outputs and counters
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic irq_i = 1'b0;
   logic [7:0] irq_vec_i = 8'h40;
   logic [7:0] io_rdata_i, prom_data_i, io_addr_o, io_wdata_o, psc_o;
   logic [13:0] prom_addr_o;
   logic io_wr_o, io_rd_o, irq_ack_o, ep_size_o, halted_o;
   int fail_count = 0;
   int check_count = 0;
   int acks = 0;
   int cyc = 0;
   // Read data follows the port address within the cycle, as the core samples it
   always #5 clk_i = ~clk_i;
   assign io_rdata_i = io_addr_o ^ 8'h6F;
   mcs_prom_model u_mcs_prom_model (.addr_i(prom_addr_o), .data_o(prom_data_i));
   mcs_core u_mcs_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .prom_addr_o(prom_addr_o),
      .prom_data_i(prom_data_i), .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o),
      .io_wr_o(io_wr_o), .io_rd_o(io_rd_o), .io_rdata_i(io_rdata_i), .irq_i(irq_i),
      .irq_vec_i(irq_vec_i), .irq_ack_o(irq_ack_o), .psc_o(psc_o), .ep_size_o(ep_size_o),
      .halted_o(halted_o));
   // Request drops once taken, else it would be retaken after the return; hang cut-off
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (irq_ack_o === 1'b1) begin
         irq_i <= 1'b0;
         acks <= acks + 1;
      end
      if (cyc == 400) begin
         fail_count++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   // Loads sixteen bytes at address zero while reset is held for 5 cycles
   task automatic reset_core(input logic [127:0] code, input logic irq);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      irq_i <= irq;
      for (int i = 0; i < 16; i++) u_mcs_prom_model.mem[i] = code[127-8*i -: 8];
      repeat (5) @(posedge clk_i);
      chk(prom_addr_o, PC_RESET);
      chk(psc_o, PSC_RESET);
      rst_n_i <= 1'b1;
   endtask : reset_core
   // Halt must appear at the expected count or one cycle after it
   task automatic wait_halt(input int lo);
      int n;
      n = 0;
      while (halted_o !== 1'b1 && n < 200) begin
         @(negedge clk_i);
         n++;
      end
      chk(16'(n - lo) >> 1, 16'h0);
   endtask : wait_halt
   // Branches, port traffic, call into a reserved opcode and return, then halt
   task automatic t_program_flow();
      u_mcs_prom_model.mem[16] = 8'h00;
      u_mcs_prom_model.mem[32] = 8'h1E;
      u_mcs_prom_model.mem[33] = 8'h3F;
      reset_core(128'h19A5_B006_2020_2A1F_2933_2AFF_9020_A012, 1'b0);
      wait_halt(58);
      chk(psc_o, 8'h5C);
      chk(ep_size_o, 1'b1);
      chk(u_mcs_core.u_ram.mem[0], 8'h0E);
      chk(u_mcs_core.u_ram.mem[1], 8'h00);
      $display("program flow test done");
   endtask : t_program_flow
   // Pending request taken right after enable, serviced and returned from
   task automatic t_interrupt();
      u_mcs_prom_model.mem[64] = 8'h73;
      reset_core(128'h7200_2020_2020_2020_2020_2020_2020_2020, 1'b1);
      wait_halt(30);
      chk(16'(acks), 16'h1);
      chk(u_mcs_core.u_ram.mem[0], 8'h01);
      $display("interrupt test done");
   endtask : t_interrupt
   // Moves the program stack, uses the data stack and crosses a page;
   // calls the subroutine left at 0x20 by the flow test
   task automatic t_stacks();
      u_mcs_prom_model.mem[266] = 8'h00;
      reset_core(128'h1980_602D_0105_2C90_201F_2020_2020_2020, 1'b0);
      wait_halt(55);
      chk(u_mcs_core.u_ram.mem[8'hFF], 8'h80);
      chk(u_mcs_core.x_q, 8'h80);
      chk(u_mcs_core.dsp_q, 8'h00);
      chk(u_mcs_core.u_ram.mem[8'h80], 8'h09);
      chk(u_mcs_core.u_ram.mem[8'h81], 8'h00);
      chk(prom_addr_o, 14'h010B);
      $display("stack and page test done");
   endtask : t_stacks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   initial begin
      t_program_flow();
      t_interrupt();
      t_stacks();
      end_sim();
   end
endmodule : mcu_core_sequencing_test
`default_nettype wire
